// file: core/cms_defs.svh
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH

// ----------------------------------------------------------------
// widths and output levels
// ----------------------------------------------------------------
`define CMS_MV_W          11
`define CMS_MV_FULL       11'h3E8
`define CMS_MV_OFF        11'h000
`define CMS_SAFE_DISABLED 11'h000
`define CMS_BAND_ONOFF    16'h0000
`define CMS_LBD_OFF       8'h00

// ----------------------------------------------------------------
// i/o channel function codes
// ----------------------------------------------------------------
`define CMS_IO_FUNC_OFF   3'h0
`define CMS_IO_FUNC_LBD   3'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CMS_MINUTE_S      60
`define CMS_CLK_HZ        25000000
`define CMS_MINUTE_CYCLES (`CMS_MINUTE_S * `CMS_CLK_HZ)

// ----------------------------------------------------------------
// control arithmetic
// ----------------------------------------------------------------
`define CMS_LBD_DELTA     16'h000A
`define CMS_INTEG_SHIFT   8
`define CMS_PID_SCALE     48'sh0000000003E8

// ----------------------------------------------------------------
// reset values of the configuration
// ----------------------------------------------------------------
`define CMS_RST_SP        16'h0000
`define CMS_RST_BAND      16'h0000
`define CMS_RST_IRATE     16'h0000
`define CMS_RST_DTIME     16'h0000
`define CMS_RST_LBD       8'h00
`define CMS_RST_SAFE      11'h000
`define CMS_RST_RUN       1'h0

`endif

// file: core/cms_pkg.sv
`include "cms_defs.svh"

package cms_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {cms_mode_auto, cms_mode_manual} cms_mode_e;

  typedef enum logic [2:0] {
    cms_stopped,
    cms_pid,
    cms_onoff,
    cms_manual,
    cms_safe
  } cms_state_e;

  typedef logic [2:0]           cms_iofunc_t;
  typedef logic [`CMS_MV_W-1:0] cms_mv_t;

  typedef struct packed {
    logic signed [15:0] setpoint;
    logic [15:0]        proportional_band;
    logic [15:0]        integral_rate;
    logic [15:0]        derivative_time;
    logic [7:0]         lbd_minutes;
    cms_mv_t            sensor_fail_output_value;
    cms_mode_e          mode;
    logic               run;
  } cms_cfg_s;

  localparam cms_cfg_s cms_cfg_reset = '{
    setpoint:                 `CMS_RST_SP,
    proportional_band:        `CMS_RST_BAND,
    integral_rate:            `CMS_RST_IRATE,
    derivative_time:          `CMS_RST_DTIME,
    lbd_minutes:              `CMS_RST_LBD,
    sensor_fail_output_value: `CMS_RST_SAFE,
    mode:                     cms_mode_auto,
    run:                      `CMS_RST_RUN
  };

endpackage

// file: core/cms_pid.sv
`include "cms_defs.svh"

module cms_pid (
  // clock and reset
  input  logic               clk,
  input  logic               reset_n,
  // control
  input  logic               step,
  input  logic               track,
  input  cms_pkg::cms_mv_t   track_value,
  // operands
  input  logic signed [15:0] setpoint,
  input  logic signed [15:0] pv,
  input  logic [15:0]        proportional_band,
  input  logic [15:0]        integral_rate,
  input  logic [15:0]        derivative_time,
  // result
  output cms_pkg::cms_mv_t   mv
);
  import cms_pkg::*;

  logic signed [47:0] integ;
  logic signed [15:0] pv_prev;
  logic signed [47:0] err;
  logic signed [47:0] p_term;
  logic signed [47:0] d_term;
  logic signed [47:0] next_integ;
  logic signed [47:0] sum;
  logic signed [47:0] full;

  // ----------------------------------------------------------------
  // deviation, rate and accumulated terms
  // ----------------------------------------------------------------
  always_comb begin
    full       = 48'($signed({1'b0, `CMS_MV_FULL}));
    err        = 48'(setpoint) - 48'(pv);
    if (proportional_band == `CMS_BAND_ONOFF) begin
      p_term = '0;
    end else begin
      p_term = (err * `CMS_PID_SCALE) / 48'($signed({1'b0, proportional_band}));
    end
    d_term     = (48'(pv_prev) - 48'(pv)) * 48'($signed({1'b0, derivative_time}));
    next_integ = integ + ((err * 48'($signed({1'b0, integral_rate}))) >>> `CMS_INTEG_SHIFT);
    if (next_integ > full) begin
      next_integ = full;
    end else if (next_integ < 48'sh0) begin
      next_integ = 48'sh0;
    end
    sum        = p_term + next_integ + d_term;
  end

  // ----------------------------------------------------------------
  // integrator and output, preloaded while tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      integ   <= 48'sh0;
      pv_prev <= 16'sh0000;
      mv      <= `CMS_MV_OFF;
    end else if (track) begin
      integ   <= 48'($signed({1'b0, track_value}));
      pv_prev <= pv;
      mv      <= track_value;
    end else if (step) begin
      integ   <= next_integ;
      pv_prev <= pv;
      if (sum > full) begin
        mv <= `CMS_MV_FULL;
      end else if (sum < 48'sh0) begin
        mv <= `CMS_MV_OFF;
      end else begin
        mv <= sum[`CMS_MV_W-1:0];
      end
    end
  end

endmodule

// file: core/cms_lbd.sv
`include "cms_defs.svh"

module cms_lbd #(
  parameter int unsigned MINUTE_CYCLES = `CMS_MINUTE_CYCLES,
  parameter logic [15:0] LBD_DELTA     = `CMS_LBD_DELTA
) (
  // clock and reset
  input  logic               clk,
  input  logic               reset_n,
  // control
  input  logic               enable,
  input  logic               restart,
  input  logic [7:0]         minutes,
  // process
  input  logic signed [15:0] pv,
  input  logic               pv_valid,
  // status
  output logic               loop_break
);
  import cms_pkg::*;

  logic [30:0]        cyc_count;
  logic [7:0]         min_count;
  logic signed [15:0] pv_ref;
  logic signed [16:0] diff;
  logic [16:0]        mag;
  logic               response;
  logic               tick;
  logic               timeout;

  always_comb begin
    diff     = 17'(pv) - 17'(pv_ref);
    mag      = diff[16] ? 17'(-diff) : diff;
    response = pv_valid && (mag >= 17'({1'b0, LBD_DELTA}));
    tick     = (cyc_count == 31'(MINUTE_CYCLES - 1));
    timeout  = enable && tick && ((min_count + 8'h01) >= minutes);
  end

  // ----------------------------------------------------------------
  // minute timer, restarted by a response or by re-enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_count <= 31'h0;
      min_count <= 8'h00;
      pv_ref    <= 16'sh0000;
    end else if (restart || response || !enable) begin
      cyc_count <= 31'h0; // see RULE13
      min_count <= 8'h00;
      pv_ref    <= pv;
    end else if (tick) begin
      cyc_count <= 31'h0;
      if (!loop_break) begin
        min_count <= min_count + 8'h01;
      end
    end else begin
      cyc_count <= cyc_count + 31'h1;
    end
  end

  // ----------------------------------------------------------------
  // loop-break flag, timeout wins over a response
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loop_break <= 1'b0;
    end else if (!enable) begin
      loop_break <= 1'b0; // see RULE7
    end else if (timeout) begin
      loop_break <= 1'b1; // see RULE5
    end else if (restart || response) begin
      loop_break <= 1'b0;
    end
  end

  a_lbd_timeout: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(loop_break) |-> $past(enable && tick && (min_count + 8'h01 >= minutes))) // see RULE5
    else $error("loop break raised without a full interval");

  a_lbd_restart: assert property (@(posedge clk) disable iff (!reset_n)
    (restart && enable) |=> (min_count == 8'h00 && cyc_count == 31'h0)) // see RULE13
    else $error("interval timer not restarted");

endmodule

// file: core/cms_supervisor.sv
`include "cms_defs.svh"

// Notes on behaviour
// RULE1 - automatic mode computes output power from setpoint and control terms
// RULE2 - manual mode applies operator power level; mode field selects auto or manual
// RULE3 - zero proportional band gives on/off action at zero or full power
// RULE4 - nonzero band gives PID action from deviation, rate and accumulated error
// RULE5 - loop break flagged when process value does not respond within set minutes
// RULE6 - channels assigned the loop-break function are active during loop break
// RULE7 - zero loop-break interval disables detection and its outputs
// RULE8 - broken sensor forces output to the configured safe value
// RULE9 - safe value zero disables substitution; output simply switched off
// RULE10 - host reads and writes settings over a serial Modbus link; no link here, settings are only loaded in parallel from cfg_in on cfg_load
// RULE11 - auto/manual switching is bumpless; output continues from present value
// RULE12 - run setting off keeps control outputs and alarms disabled
// RULE13 - loop-break timer restarts on process response and on control re-enable
module cms_supervisor #(
  parameter int          N_IO          = 3,
  parameter int unsigned MINUTE_CYCLES = `CMS_MINUTE_CYCLES,
  parameter logic [15:0] LBD_DELTA     = `CMS_LBD_DELTA
) (
  // clock and reset
  input  logic                                clk,
  input  logic                                reset_n,
  // configuration
  input  cms_pkg::cms_cfg_s                   cfg_in,
  input  logic                                cfg_load,
  input  cms_pkg::cms_iofunc_t [N_IO-1:0]     io_func,
  input  cms_pkg::cms_mv_t                    manual_mv,
  input  logic                                manual_load,
  // process input
  input  logic signed [15:0]                  pv,
  input  logic                                pv_valid,
  input  logic                                sensor_fail,
  // outputs
  output cms_pkg::cms_mv_t                    mv_out,
  output logic                                output_on,
  output logic                                manual_active,
  output logic                                run_active,
  output logic                                loop_break_display,
  output logic [N_IO-1:0]                     io_out
);
  import cms_pkg::*;

  cms_cfg_s   cfg;
  cms_state_e state;
  cms_state_e next_state;
  cms_mv_t    man_mv;
  cms_mv_t    onoff_mv;
  cms_mv_t    pid_mv;
  cms_mv_t    safe_mv;
  cms_mv_t    next_mv;
  logic       lbd_flag;
  logic       lbd_enable;
  logic       lbd_restart;
  logic       lbd_active;

  // ----------------------------------------------------------------
  // configuration held from the host side
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= cms_cfg_reset;
    end else if (cfg_load) begin
      cfg <= cfg_in; // see RULE10
    end
  end

  // ----------------------------------------------------------------
  // mode selection
  // ----------------------------------------------------------------
  always_comb begin
    if (!cfg.run) begin
      next_state = cms_stopped; // see RULE12
    end else if (sensor_fail) begin
      next_state = cms_safe; // see RULE8
    end else if (cfg.mode == cms_mode_manual) begin
      next_state = cms_manual; // see RULE2
    end else if (cfg.proportional_band == `CMS_BAND_ONOFF) begin
      next_state = cms_onoff; // see RULE3
    end else begin
      next_state = cms_pid; // see RULE4
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= cms_stopped;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // manual level, preloaded on entry
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      man_mv <= `CMS_MV_OFF;
    end else if (state != cms_manual && next_state == cms_manual) begin
      man_mv <= mv_out; // see RULE11
    end else if (manual_load) begin
      man_mv <= (manual_mv > `CMS_MV_FULL) ? `CMS_MV_FULL : manual_mv; // see RULE2
    end
  end

  // ----------------------------------------------------------------
  // on/off action
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      onoff_mv <= `CMS_MV_OFF;
    end else if (pv_valid) begin
      onoff_mv <= (pv < cfg.setpoint) ? `CMS_MV_FULL : `CMS_MV_OFF; // see RULE3
    end
  end

  // ----------------------------------------------------------------
  // pid action, tracking the output when not in charge
  // ----------------------------------------------------------------
  cms_pid u_pid (
    .clk               (clk),
    .reset_n           (reset_n),
    .step              (pv_valid && state == cms_pid), // see RULE4
    .track             (state != cms_pid), // see RULE11
    .track_value       (mv_out),
    .setpoint          (cfg.setpoint),
    .pv                (pv),
    .proportional_band (cfg.proportional_band),
    .integral_rate     (cfg.integral_rate),
    .derivative_time   (cfg.derivative_time),
    .mv                (pid_mv)
  );

  // ----------------------------------------------------------------
  // output selection
  // ----------------------------------------------------------------
  always_comb begin
    if (cfg.sensor_fail_output_value == `CMS_SAFE_DISABLED) begin
      safe_mv = `CMS_MV_OFF; // see RULE9
    end else if (cfg.sensor_fail_output_value > `CMS_MV_FULL) begin
      safe_mv = `CMS_MV_FULL;
    end else begin
      safe_mv = cfg.sensor_fail_output_value; // see RULE8
    end
    unique case (state)
      cms_stopped: next_mv = `CMS_MV_OFF; // see RULE12
      cms_safe:    next_mv = safe_mv;
      cms_manual:  next_mv = man_mv;
      cms_onoff:   next_mv = onoff_mv;
      cms_pid:     next_mv = pid_mv; // see RULE1
      default:     next_mv = `CMS_MV_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mv_out    <= `CMS_MV_OFF;
      output_on <= 1'b0;
    end else begin
      mv_out    <= next_mv;
      output_on <= (next_mv != `CMS_MV_OFF);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      manual_active <= 1'b0;
      run_active    <= 1'b0;
    end else begin
      manual_active <= (cfg.mode == cms_mode_manual);
      run_active    <= cfg.run;
    end
  end

  // ----------------------------------------------------------------
  // loop-break watchdog
  // ----------------------------------------------------------------
  assign lbd_enable  = cfg.run && !sensor_fail && (cfg.lbd_minutes != `CMS_LBD_OFF);
  assign lbd_restart = cfg.run && !run_active;
  assign lbd_active  = lbd_flag && lbd_enable;

  cms_lbd #(
    .MINUTE_CYCLES (MINUTE_CYCLES),
    .LBD_DELTA     (LBD_DELTA)
  ) u_lbd (
    .clk        (clk),
    .reset_n    (reset_n),
    .enable     (lbd_enable), // see RULE7
    .restart    (lbd_restart), // see RULE13
    .minutes    (cfg.lbd_minutes),
    .pv         (pv),
    .pv_valid   (pv_valid),
    .loop_break (lbd_flag)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loop_break_display <= 1'b0;
    end else begin
      loop_break_display <= lbd_active; // see RULE5
    end
  end

  // ----------------------------------------------------------------
  // i/o channels
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N_IO; gi++) begin : g_io
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          io_out[gi] <= 1'b0;
        end else begin
          io_out[gi] <= lbd_active && (io_func[gi] == `CMS_IO_FUNC_LBD); // see RULE6
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_stop_outputs_off: assert property (@(posedge clk) disable iff (!reset_n) // see RULE12
    (!cfg.run)[*2] |=> (mv_out == `CMS_MV_OFF && !output_on && io_out == '0))
    else $error("outputs active while stopped");

  a_safe_value: assert property (@(posedge clk) disable iff (!reset_n) // see RULE8
    (cfg.run && sensor_fail && !cfg_load
     && cfg.sensor_fail_output_value != `CMS_SAFE_DISABLED
     && cfg.sensor_fail_output_value <= `CMS_MV_FULL)[*2]
    |=> (mv_out == cfg.sensor_fail_output_value && output_on))
    else $error("safe value not applied on sensor failure");

  a_safe_switch_off: assert property (@(posedge clk) disable iff (!reset_n) // see RULE9
    (cfg.run && sensor_fail && !cfg_load
     && cfg.sensor_fail_output_value == `CMS_SAFE_DISABLED)[*2]
    |=> (mv_out == `CMS_MV_OFF && !output_on))
    else $error("output not switched off on sensor failure");

  a_onoff_level: assert property (@(posedge clk) disable iff (!reset_n) // see RULE3
    pv_valid |=> (onoff_mv == ($past(pv < cfg.setpoint) ? `CMS_MV_FULL : `CMS_MV_OFF)))
    else $error("on/off level wrong for deviation");

  a_onoff_drive: assert property (@(posedge clk) disable iff (!reset_n) // see RULE3
    (state == cms_onoff) |=> (mv_out == $past(onoff_mv)
                             && (mv_out == `CMS_MV_FULL || mv_out == `CMS_MV_OFF)))
    else $error("on/off mode drove an intermediate level");

  a_pid_drive: assert property (@(posedge clk) disable iff (!reset_n) // see RULE4
    (state == cms_pid) |=> (mv_out == $past(pid_mv)))
    else $error("pid mode output not taken from pid");

  a_mode_select: assert property (@(posedge clk) disable iff (!reset_n) // see RULE1
    (cfg.run && !sensor_fail && cfg.mode == cms_mode_auto && !cfg_load)
    |=> (state == cms_pid || state == cms_onoff))
    else $error("automatic mode not selected");

  a_manual_apply: assert property (@(posedge clk) disable iff (!reset_n) // see RULE2
    (state == cms_manual && manual_load && manual_mv <= `CMS_MV_FULL)
    |=> (man_mv == $past(manual_mv)) ##1 (state != cms_manual || mv_out == $past(man_mv)))
    else $error("operator level not applied in manual");

  a_bumpless_entry: assert property (@(posedge clk) disable iff (!reset_n) // see RULE11
    (state != cms_manual && next_state == cms_manual) |=> (man_mv == $past(mv_out)))
    else $error("manual entry not bumpless");

  a_lbd_disabled: assert property (@(posedge clk) disable iff (!reset_n) // see RULE7
    (cfg.lbd_minutes == `CMS_LBD_OFF) |=> (!loop_break_display && io_out == '0))
    else $error("loop break active while disabled");

  a_lbd_channel: assert property (@(posedge clk) disable iff (!reset_n) // see RULE6
    (lbd_active && io_func[0] == `CMS_IO_FUNC_LBD) |=> (io_out[0] && loop_break_display))
    else $error("loop-break channel not driven");

  a_safe_priority: assert property (@(posedge clk) disable iff (!reset_n) // see RULE8
    (cfg.run && sensor_fail) |=> (state == cms_safe))
    else $error("sensor failure did not select the safe output");

  a_manual_select: assert property (@(posedge clk) disable iff (!reset_n) // see RULE2
    (cfg.run && !sensor_fail && cfg.mode == cms_mode_manual) |=> (state == cms_manual))
    else $error("manual mode not selected");

  a_run_gate_alarm: assert property (@(posedge clk) disable iff (!reset_n) // see RULE12
    (!cfg.run) |=> (state == cms_stopped && !loop_break_display))
    else $error("alarm or control active while stopped");

  a_pid_tracking: assert property (@(posedge clk) disable iff (!reset_n) // see RULE11
    (state != cms_pid) |=> (pid_mv == $past(mv_out)))
    else $error("pid output not tracking while idle");

  c_onoff_run:    cover property (@(posedge clk) disable iff (!reset_n)
    state == cms_onoff ##1 mv_out == `CMS_MV_FULL);
  c_manual_entry: cover property (@(posedge clk) disable iff (!reset_n)
    state == cms_pid ##1 state == cms_manual);
  c_safe_state:   cover property (@(posedge clk) disable iff (!reset_n)
    state == cms_safe && mv_out != `CMS_MV_OFF);
  c_loop_break:   cover property (@(posedge clk) disable iff (!reset_n)
    $rose(loop_break_display));
  c_pid_run:      cover property (@(posedge clk) disable iff (!reset_n)
    state == cms_pid ##1 mv_out != `CMS_MV_OFF);

endmodule

// file: testbench/cms_process_model.sv
module cms_process_model (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // actuator side
  input  cms_pkg::cms_mv_t         mv,
  // scenario control
  input  wire logic signed [15:0]  pv_base,
  input  wire logic                freeze,
  input  wire logic                broken,
  // sensor side
  output logic signed [15:0]       pv,
  output logic                     pv_valid,
  output logic                     sensor_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  import cms_pkg::*;

  logic [1:0] phase;
  logic       wobble;

  // ----------------------------------------------------------------
  // sampling: one new value every fourth cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase    <= 2'h0;
      pv_valid <= 1'b0;
    end else begin
      phase    <= phase + 2'h1;
      pv_valid <= (phase == 2'h3);
    end
  end

  // ----------------------------------------------------------------
  // process value: reacts to power unless frozen
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pv          <= 16'sh0000;
      wobble      <= 1'b0;
      sensor_fail <= 1'b0;
    end else begin
      sensor_fail <= broken;
      if (phase == 2'h3 && !freeze && mv != 11'h000) begin
        wobble <= !wobble;
      end
      // broken sensor reads garbage that changes every cycle
      if (broken) begin
        pv <= ~pv;
      end else begin
        pv <= pv_base + ((wobble && !freeze) ? 16'sh0010 : 16'sh0000);
      end
    end
  end
endmodule

// file: testbench/tb_control_mode_supervisor.sv
`include "cms_defs.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module tb_control_mode_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  import cms_pkg::*;

  logic               clk, reset_n, cfg_load, manual_load, freeze, broken;
  logic               pv_valid, sensor_fail, output_on, manual_active;
  logic               run_active, loop_break_display;
  cms_cfg_s           cfg;
  cms_iofunc_t [2:0]  io_func;
  cms_mv_t            manual_mv, mv_out;
  logic signed [15:0] pv, pv_base;
  logic [2:0]         io_out;
  int                 errors, check_count, cycles;

  cms_supervisor #(.N_IO(3), .MINUTE_CYCLES(20)) DUT (
    .clk(clk), .reset_n(reset_n), .cfg_in(cfg), .cfg_load(cfg_load),
    .io_func(io_func), .manual_mv(manual_mv), .manual_load(manual_load),
    .pv(pv), .pv_valid(pv_valid), .sensor_fail(sensor_fail),
    .mv_out(mv_out), .output_on(output_on), .manual_active(manual_active),
    .run_active(run_active), .loop_break_display(loop_break_display), .io_out(io_out));

  cms_process_model plant (
    .clk(clk), .reset_n(reset_n), .mv(mv_out), .pv_base(pv_base), .freeze(freeze),
    .broken(broken), .pv(pv), .pv_valid(pv_valid), .sensor_fail(sensor_fail));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task set_cfg(input logic [15:0] pb, input cms_mode_e md, input logic rn,
               input logic [7:0] lbd, input cms_mv_t safe);
    @(posedge clk);
    cfg <= '{setpoint: 16'sh0064, proportional_band: pb, integral_rate: 16'h0000,
             derivative_time: 16'h0000, lbd_minutes: lbd,
             sensor_fail_output_value: safe, mode: md, run: rn};
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
  endtask

  task wait_lbd(input logic lvl, input int lim);
    for (int i = 0; i < lim && loop_break_display !== lvl; i++) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_onoff;
    set_cfg(16'h0000, cms_mode_auto, 1'b1, 8'h00, 11'h000);
    tick(12);
    `CHK(mv_out, 11'h3E8)
    `CHK(output_on, 1'b1)
    `CHK(run_active, 1'b1)
    @(posedge clk);
    pv_base <= 16'sh0096;
    tick(12);
    `CHK(mv_out, 11'h000)
    @(posedge clk);
    pv_base <= 16'sh0032;
    tick(12);
  endtask

  task t_manual;
    set_cfg(16'h0000, cms_mode_manual, 1'b1, 8'h00, 11'h000);
    tick(6);
    `CHK(manual_active, 1'b1)
    `CHK(mv_out, 11'h3E8)
    @(posedge clk);
    manual_mv   <= 11'h1F4;
    manual_load <= 1'b1;
    @(posedge clk);
    manual_load <= 1'b0;
    tick(4);
    `CHK(mv_out, 11'h1F4)
  endtask

  task t_pid;
    set_cfg(16'h0000, cms_mode_auto, 1'b0, 8'h00, 11'h000);
    freeze <= 1'b1;
    tick(4);
    set_cfg(16'h0064, cms_mode_auto, 1'b1, 8'h00, 11'h000);
    tick(12);
    `CHK(mv_out, 11'h1F4)
    `CHK(manual_active, 1'b0)
  endtask

  task t_sensor;
    set_cfg(16'h0000, cms_mode_auto, 1'b1, 8'h00, 11'h12C);
    broken <= 1'b1;
    tick(6);
    `CHK(mv_out, 11'h12C)
    set_cfg(16'h0000, cms_mode_auto, 1'b1, 8'h00, 11'h000);
    tick(4);
    `CHK(mv_out, 11'h000)
    `CHK(output_on, 1'b0)
    @(posedge clk);
    broken <= 1'b0;
    tick(4);
  endtask

  task t_lbd;
    set_cfg(16'h0000, cms_mode_auto, 1'b0, 8'h02, 11'h000);
    freeze <= 1'b1;
    set_cfg(16'h0000, cms_mode_auto, 1'b1, 8'h02, 11'h000);
    tick(30);
    `CHK(loop_break_display, 1'b0)
    wait_lbd(1'b1, 30);
    `CHK(loop_break_display, 1'b1)
    `CHK(io_out, 3'b101)
    @(posedge clk);
    freeze <= 1'b0;
    wait_lbd(1'b0, 20);
    `CHK(loop_break_display, 1'b0)
    `CHK(io_out, 3'b000)
    @(posedge clk);
    freeze <= 1'b1;
    set_cfg(16'h0000, cms_mode_auto, 1'b1, 8'h00, 11'h000);
    tick(100);
    `CHK(loop_break_display, 1'b0)
    `CHK(io_out, 3'b000)
  endtask

  task t_run_off;
    set_cfg(16'h0000, cms_mode_auto, 1'b0, 8'h02, 11'h000);
    tick(4);
    `CHK(mv_out, 11'h000)
    `CHK(output_on, 1'b0)
    `CHK(run_active, 1'b0)
  endtask

  // ----------------------------------------------------------------
  // verdict and watchdog
  // ----------------------------------------------------------------
  task tally_and_finish;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    clk         = 1'b0;
    reset_n     = 1'b0;
    cfg         = cms_cfg_reset;
    cfg_load    = 1'b0;
    io_func     = {`CMS_IO_FUNC_LBD, `CMS_IO_FUNC_OFF, `CMS_IO_FUNC_LBD};
    manual_mv   = 11'h000;
    manual_load = 1'b0;
    pv_base     = 16'sh0032;
    freeze      = 1'b0;
    broken      = 1'b0;
    errors      = 0;
    check_count = 0;
    cycles      = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    tick(2);
    `CHK(mv_out, 11'h000)
    `CHK(run_active, 1'b0)
    t_onoff();
    t_manual();
    t_pid();
    t_sensor();
    t_lbd();
    t_run_off();
    tally_and_finish();
  end
endmodule
